// File: nvx_pkg.sv
// Shared constants and types for the nonvolatile I/O expander core
// Operation
// - Capture TDI on TCK rise, TDO on fall
// - TMS sampled on TCK rise steps TAP
// - Address-select pins form low slave address bits
// - Nine pins: input path plus open-drain pulldown
// - Pullup-enable bit per pin connects pullup
// - Drive-control bit per pin: pulldown or high-Z
// - Clear bit pulls low; pin 8 at bit0
// - Status registers return actual pin levels
// - Drive and pullup registers read back settings
// - Shadowed NV cells; shadow copy drives pins
// - Three classes; NV write starts write cycle
// - NV write after stop, within 20 ms
// - Shadow-write-disable is configuration bit 0
// - Disable clear: write shadow and NV, timed
// - Disable set: shadow only, no write time
// - Registers and user memory via both ports
// - Each address belongs to one memory kind
package nvx_pkg;
  // Clock and write-cycle timing
  localparam int NVX_CLK_HZ = 100_000_000;
  localparam int NVX_NV_WRITE_TIME_MS = 20;
  localparam int NVX_NV_WRITE_CYCLES = NVX_NV_WRITE_TIME_MS * (NVX_CLK_HZ / 1000);
  // Pin count and slave address high nibble (value arbitrary)
  localparam int NVX_PINS = 9;
  localparam logic [3:0] NVX_DEV_ADDR_HI = 4'hA;
  // Register map
  localparam logic [7:0] NVX_USER_LAST = 8'h3F;
  localparam logic [7:0] NVX_NVRSV_FIRST = 8'hE8;
  localparam logic [7:0] NVX_NVRSV_LAST = 8'hEF;
  localparam logic [7:0] NVX_PULLUP_ENABLE_LOW = 8'hF0;
  localparam logic [7:0] NVX_PULLUP_ENABLE_HIGH = 8'hF1;
  localparam logic [7:0] NVX_PIN_DRIVE_CONTROL_LOW = 8'hF2;
  localparam logic [7:0] NVX_PIN_DRIVE_CONTROL_HIGH = 8'hF3;
  localparam logic [7:0] NVX_CONFIGURATION = 8'hF4;
  localparam logic [7:0] NVX_USER2_FIRST = 8'hF5;
  localparam logic [7:0] NVX_USER2_LAST = 8'hF7;
  localparam logic [7:0] NVX_PIN_LEVEL_STATUS_LOW = 8'hF8;
  localparam logic [7:0] NVX_PIN_LEVEL_STATUS_HIGH = 8'hF9;
  localparam logic [7:0] NVX_SRAM_FIRST = 8'hFA;
  localparam int NVX_SHADOW_COUNT = 5;
  localparam int NVX_SRAM_COUNT = 6;
  // Field positions and factory values
  localparam int NVX_CFG_SEE_BIT = 0;
  localparam logic [7:0] NVX_PULLUP_RESET = 8'h00;
  localparam logic [7:0] NVX_DRIVE_LOW_RESET = 8'hFF;
  localparam logic [7:0] NVX_DRIVE_HIGH_RESET = 8'h01;
  localparam logic [7:0] NVX_CFG_RESET = 8'h00;
  localparam logic [7:0] NVX_USER_RESET = 8'h00;
  // JTAG instruction codes (three-bit IR)
  localparam int NVX_IR_W = 3;
  localparam logic [2:0] NVX_IR_ADDRESS = 3'h1;
  localparam logic [2:0] NVX_IR_READ = 3'h2;
  localparam logic [2:0] NVX_IR_WRITE = 3'h3;
  localparam logic [2:0] NVX_IR_BYPASS = 3'h7;
  // Memory kind of an address
  typedef enum logic [2:0] {
    NVX_K_NONE, NVX_K_NV, NVX_K_SHADOW, NVX_K_CFG, NVX_K_SRAM, NVX_K_STATUS
  } nvx_kind_t;
endpackage

// File: nvx_mem_if.sv
// Port between the core and its nonvolatile cell array
interface nvx_mem_if;
  logic [7:0] addr;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output addr, output wr_en, output wdata, input rdata);
  modport mem (input addr, input wr_en, input wdata, output rdata);
endinterface

// File: nvx_nv_array.sv
// Nonvolatile cell array model with registered read data
module nvx_nv_array
  import nvx_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Array port
  nvx_mem_if.mem port
);
  // Factory contents; no reset, so cells keep their value across reset like real NV storage
  logic [7:0] cells [256] = '{NVX_PIN_DRIVE_CONTROL_LOW: NVX_DRIVE_LOW_RESET,
                              NVX_PIN_DRIVE_CONTROL_HIGH: NVX_DRIVE_HIGH_RESET, default: NVX_USER_RESET};

  // Write port
  always_ff @(posedge mclk_i)
  begin
    if (port.wr_en)
    begin
      cells[port.addr] <= port.wdata;
    end
  end

  // Read data one cycle after the address
  always_ff @(posedge mclk_i)
  begin
    port.rdata <= cells[port.addr];
  end
endmodule

// File: nvx_core.sv
// Expander core: two-wire slave, JTAG TAP, shadowed pin registers
module nvx_core #(
  parameter int NV_WRITE_CYCLES = nvx_pkg::NVX_NV_WRITE_CYCLES,
  parameter logic [3:0] DEV_ADDR_HI = nvx_pkg::NVX_DEV_ADDR_HI
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Two-wire port
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_select_bit0_i,
  input wire logic addr_select_bit1_i,
  input wire logic addr_select_bit2_i,
  // JTAG port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  // I/O pins
  input wire logic [nvx_pkg::NVX_PINS-1:0] io_i,
  output logic [nvx_pkg::NVX_PINS-1:0] io_o,
  output logic [nvx_pkg::NVX_PINS-1:0] io_oe_n_o,
  output logic [nvx_pkg::NVX_PINS-1:0] pullup_en_o,
  // Status
  output logic nv_busy_o
);
  import nvx_pkg::*;

  localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);
  localparam int NSYNC = 8 + NVX_PINS;

  typedef enum logic [4:0] {
    I_IDLE = 5'h01, I_RX = 5'h02, I_ACK = 5'h04, I_TX = 5'h08, I_MACK = 5'h10
  } nvx_i2c_t;

  typedef enum logic [15:0] {
    T_RESET = 16'h0001, T_IDLE = 16'h0002, T_SEL_DR = 16'h0004, T_CAP_DR = 16'h0008,
    T_SHF_DR = 16'h0010, T_EX1_DR = 16'h0020, T_PAU_DR = 16'h0040, T_EX2_DR = 16'h0080,
    T_UPD_DR = 16'h0100, T_SEL_IR = 16'h0200, T_CAP_IR = 16'h0400, T_SHF_IR = 16'h0800,
    T_EX1_IR = 16'h1000, T_PAU_IR = 16'h2000, T_EX2_IR = 16'h4000, T_UPD_IR = 16'h8000
  } nvx_tap_t;

  // Classify an address into exactly one memory kind
  function automatic nvx_kind_t addr_kind(input logic [7:0] a);
    if (a <= NVX_USER_LAST) return NVX_K_NV;
    if (a >= NVX_NVRSV_FIRST && a <= NVX_NVRSV_LAST) return NVX_K_NV;
    if (a >= NVX_PULLUP_ENABLE_LOW && a <= NVX_PIN_DRIVE_CONTROL_HIGH) return NVX_K_SHADOW;
    if (a == NVX_CONFIGURATION) return NVX_K_CFG;
    if (a >= NVX_USER2_FIRST && a <= NVX_USER2_LAST) return NVX_K_NV;
    if (a == NVX_PIN_LEVEL_STATUS_LOW || a == NVX_PIN_LEVEL_STATUS_HIGH) return NVX_K_STATUS;
    if (a >= NVX_SRAM_FIRST) return NVX_K_SRAM;
    return NVX_K_NONE;
  endfunction

  // TAP next state from the sampled mode-select level
  function automatic nvx_tap_t tap_next(input nvx_tap_t s, input logic m);
    case (s)
      T_RESET: return m ? T_RESET : T_IDLE;
      T_IDLE: return m ? T_SEL_DR : T_IDLE;
      T_SEL_DR: return m ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: return m ? T_EX1_DR : T_SHF_DR;
      T_SHF_DR: return m ? T_EX1_DR : T_SHF_DR;
      T_EX1_DR: return m ? T_UPD_DR : T_PAU_DR;
      T_PAU_DR: return m ? T_EX2_DR : T_PAU_DR;
      T_EX2_DR: return m ? T_UPD_DR : T_SHF_DR;
      T_UPD_DR: return m ? T_SEL_DR : T_IDLE;
      T_SEL_IR: return m ? T_RESET : T_CAP_IR;
      T_CAP_IR: return m ? T_EX1_IR : T_SHF_IR;
      T_SHF_IR: return m ? T_EX1_IR : T_SHF_IR;
      T_EX1_IR: return m ? T_UPD_IR : T_PAU_IR;
      T_PAU_IR: return m ? T_EX2_IR : T_PAU_IR;
      T_EX2_IR: return m ? T_UPD_IR : T_SHF_IR;
      T_UPD_IR: return m ? T_SEL_DR : T_IDLE;
      default: return T_RESET;
    endcase
  endfunction

  nvx_mem_if mem ();

  logic [NSYNC-1:0] sync_meta;
  logic [NSYNC-1:0] sync_q;
  logic scl_s, sda_s, tck_s, tms_s, tdi_s;
  logic [2:0] addr_sel;
  logic [NVX_PINS-1:0] pins_s;
  logic scl_d, sda_d, tck_d;
  logic scl_rise, scl_fall, start_det, stop_det, tck_rise, tck_fall;
  logic [7:0] shadow [NVX_SHADOW_COUNT];
  logic [7:0] sram [NVX_SRAM_COUNT];
  logic see;
  logic [2:0] ld_step;
  logic ld_done;
  logic [BUSY_W-1:0] busy_cnt;
  logic busy, i2c_dirty;
  logic [7:0] rd_addr, rd_value;
  logic wr_req, wr_jtag, nv_write;
  logic [7:0] wr_addr, wr_data;
  nvx_kind_t wr_kind;
  nvx_i2c_t i2c_st;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic rw, master_ack, sda_low;
  logic [7:0] rx_sreg, tx_sreg, ptr;
  logic i2c_wr;
  logic [7:0] i2c_waddr, i2c_wdata;
  nvx_tap_t tap;
  logic [NVX_IR_W-1:0] ir, ir_sreg;
  logic [7:0] dr_sreg, jtag_addr;
  logic byp, jtag_wr;

  nvx_nv_array u_array (
    .mclk_i(mclk_i),
    .port(mem.mem)
  );

  // Two-flop synchronisers for every pin input
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      // Idle-high two-wire lines, so no false edge follows reset
      sync_meta <= NSYNC'(3);
      sync_q <= NSYNC'(3);
    end
    else
    begin
      sync_meta <= {io_i, addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i,
                    tdi_i, tms_i, tck_i, sda_i, scl_i};
      sync_q <= sync_meta;
    end
  end
  assign {pins_s, addr_sel, tdi_s, tms_s, tck_s, sda_s, scl_s} = sync_q;

  // Edge detection on the synchronised clocks and data
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      tck_d <= 1'b0;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      tck_d <= tck_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // Read address: power-up load first, then JTAG when out of reset state, else two-wire
  always_comb
  begin
    if (!ld_done) rd_addr = NVX_PULLUP_ENABLE_LOW + {5'h00, ld_step};
    else if (tap != T_RESET) rd_addr = jtag_addr;
    else rd_addr = ptr;
  end

  // Read data by kind; status shows live pins, not settings
  always_comb
  begin
    rd_value = 8'h00;
    case (addr_kind(rd_addr))
      NVX_K_NV: rd_value = mem.rdata;
      NVX_K_SHADOW: rd_value = shadow[rd_addr[2:0]];
      NVX_K_CFG: rd_value = shadow[NVX_SHADOW_COUNT-1];
      NVX_K_SRAM: rd_value = sram[3'(rd_addr - NVX_SRAM_FIRST)];
      NVX_K_STATUS: rd_value = rd_addr[0] ? {7'h00, pins_s[8]} : pins_s[7:0];
      default: rd_value = 8'h00;
    endcase
  end

  // Write request from either port; two-wire address and data win if both write in the same cycle
  assign wr_req = i2c_wr | jtag_wr;
  assign wr_jtag = jtag_wr;
  assign wr_addr = i2c_wr ? i2c_waddr : jtag_addr;
  assign wr_data = i2c_wr ? i2c_wdata : dr_sreg;
  assign wr_kind = addr_kind(wr_addr);
  assign see = shadow[NVX_SHADOW_COUNT-1][NVX_CFG_SEE_BIT];
  // NV cells are refused while a write cycle runs
  assign nv_write = wr_req & ~busy & (wr_kind == NVX_K_NV || wr_kind == NVX_K_CFG ||
                    (wr_kind == NVX_K_SHADOW && !see));
  assign mem.addr = nv_write ? wr_addr : rd_addr;
  assign mem.wr_en = nv_write;
  assign mem.wdata = wr_data;

  // Power-up load of shadows from NV cells before pins are driven
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ld_step <= 3'h0;
      ld_done <= 1'b0;
    end
    else if (!ld_done)
    begin
      ld_step <= ld_step + 3'h1;
      ld_done <= (ld_step == 3'(NVX_SHADOW_COUNT));
    end
  end

  // Shadow registers: loaded at power-up, then written by either port
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      shadow[0] <= NVX_PULLUP_RESET;
      shadow[1] <= NVX_PULLUP_RESET;
      shadow[2] <= NVX_DRIVE_LOW_RESET;
      shadow[3] <= NVX_DRIVE_HIGH_RESET;
      shadow[4] <= NVX_CFG_RESET;
    end
    else if (!ld_done)
    begin
      if (ld_step != 3'h0) shadow[ld_step - 3'h1] <= mem.rdata;
    end
    else if (wr_req && wr_kind == NVX_K_SHADOW && (see || !busy))
    begin
      shadow[wr_addr[2:0]] <= wr_data;
    end
    else if (wr_req && wr_kind == NVX_K_CFG && !busy)
    begin
      shadow[NVX_SHADOW_COUNT-1] <= wr_data;
    end
  end

  // Plain volatile bytes
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < NVX_SRAM_COUNT; i++) sram[i] <= 8'h00;
    end
    else if (wr_req && wr_kind == NVX_K_SRAM)
    begin
      sram[3'(wr_addr - NVX_SRAM_FIRST)] <= wr_data;
    end
  end

  // Write-cycle timer; two-wire writes start it at stop, JTAG at update
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_cnt <= '0;
      i2c_dirty <= 1'b0;
    end
    else
    begin
      if (nv_write && wr_jtag) busy_cnt <= BUSY_W'(NV_WRITE_CYCLES);
      else if (stop_det && i2c_dirty) busy_cnt <= BUSY_W'(NV_WRITE_CYCLES);
      else if (busy_cnt != '0) busy_cnt <= busy_cnt - 1'b1;
      if (nv_write && !wr_jtag) i2c_dirty <= 1'b1;
      else if (stop_det) i2c_dirty <= 1'b0;
    end
  end
  assign busy = (busy_cnt != '0);
  assign nv_busy_o = busy;

  // Two-wire slave; busy device refuses its address so masters can poll
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      i2c_st <= I_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      rw <= 1'b0;
      master_ack <= 1'b0;
      sda_low <= 1'b0;
      rx_sreg <= 8'h00;
      tx_sreg <= 8'h00;
      ptr <= 8'h00;
      i2c_wr <= 1'b0;
      i2c_waddr <= 8'h00;
      i2c_wdata <= 8'h00;
    end
    else
    begin
      i2c_wr <= 1'b0;
      if (start_det)
      begin
        i2c_st <= I_RX;
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        sda_low <= 1'b0;
      end
      else if (stop_det)
      begin
        i2c_st <= I_IDLE;
        sda_low <= 1'b0;
      end
      else
      begin
        case (i2c_st)
          I_IDLE:
          begin
            sda_low <= 1'b0;
          end
          I_RX:
          begin
            if (scl_rise && bit_cnt != 4'h8)
            begin
              rx_sreg <= {rx_sreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (byte_idx == 2'h0)
              begin
                if (rx_sreg[7:1] == {DEV_ADDR_HI, addr_sel} && !busy)
                begin
                  rw <= rx_sreg[0];
                  sda_low <= 1'b1;
                  i2c_st <= I_ACK;
                  byte_idx <= 2'h1;
                end
                else i2c_st <= I_IDLE;
              end
              else
              begin
                sda_low <= 1'b1;
                i2c_st <= I_ACK;
                byte_idx <= 2'h2;
                if (byte_idx == 2'h1) ptr <= rx_sreg;
                else
                begin
                  i2c_wr <= 1'b1;
                  i2c_waddr <= ptr;
                  i2c_wdata <= rx_sreg;
                  ptr <= ptr + 8'h01;
                end
              end
            end
          end
          I_ACK, I_MACK:
          begin
            if (scl_rise) master_ack <= ~sda_s;
            if (scl_fall)
            begin
              if (rw && (i2c_st == I_ACK || master_ack))
              begin
                tx_sreg <= rd_value;
                ptr <= ptr + 8'h01;
                sda_low <= ~rd_value[7];
                bit_cnt <= 4'h1;
                i2c_st <= I_TX;
              end
              else
              begin
                sda_low <= 1'b0;
                i2c_st <= rw ? I_IDLE : I_RX;
              end
            end
          end
          I_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                sda_low <= 1'b0;
                i2c_st <= I_MACK;
              end
              else
              begin
                tx_sreg <= {tx_sreg[6:0], 1'b0};
                sda_low <= ~tx_sreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          default: i2c_st <= I_IDLE;
        endcase
      end
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~sda_low;

  // TAP controller and registers, stepped on TCK rising edges
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tap <= T_RESET;
      ir <= NVX_IR_BYPASS;
      ir_sreg <= '0;
      dr_sreg <= 8'h00;
      jtag_addr <= 8'h00;
      byp <= 1'b0;
      jtag_wr <= 1'b0;
    end
    else
    begin
      jtag_wr <= 1'b0;
      if (tck_rise)
      begin
        tap <= tap_next(tap, tms_s);
        case (tap)
          T_RESET: ir <= NVX_IR_BYPASS;
          T_CAP_IR: ir_sreg <= NVX_IR_W'(1);
          T_SHF_IR: ir_sreg <= {tdi_s, ir_sreg[NVX_IR_W-1:1]};
          T_UPD_IR: ir <= ir_sreg;
          T_CAP_DR:
          begin
            byp <= 1'b0;
            if (ir == NVX_IR_READ) dr_sreg <= rd_value;
            else if (ir == NVX_IR_ADDRESS) dr_sreg <= jtag_addr;
          end
          T_SHF_DR:
          begin
            if (ir == NVX_IR_ADDRESS || ir == NVX_IR_READ || ir == NVX_IR_WRITE)
              dr_sreg <= {tdi_s, dr_sreg[7:1]};
            else byp <= tdi_s;
          end
          T_UPD_DR:
          begin
            if (ir == NVX_IR_ADDRESS) jtag_addr <= dr_sreg;
            else if (ir == NVX_IR_WRITE) jtag_wr <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Test data out changes on TCK falling edges, driven only while shifting
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tdo_o <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end
    else if (tck_fall)
    begin
      tdo_oe_n_o <= ~(tap == T_SHF_DR || tap == T_SHF_IR);
      if (tap == T_SHF_IR) tdo_o <= ir_sreg[0];
      else if (ir inside {NVX_IR_ADDRESS, NVX_IR_READ, NVX_IR_WRITE}) tdo_o <= dr_sreg[0];
      else tdo_o <= byp;
    end
  end

  // Pins: released and pullups off until the shadows hold NV values
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      io_oe_n_o <= '1;
      pullup_en_o <= '0;
    end
    else if (ld_done)
    begin
      io_oe_n_o <= {shadow[3][0], shadow[2]};
      pullup_en_o <= {shadow[1][0], shadow[0]};
    end
  end
  assign io_o = '0;
endmodule

// File: nvx_core_checker.sv
// Port-level assertions and covers for the expander core
module nvx_core_checker #(
  parameter int NV_WRITE_CYCLES = 300
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Serial and test ports
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic tck_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  // Pins and status
  input wire logic [nvx_pkg::NVX_PINS-1:0] io_o,
  input wire logic [nvx_pkg::NVX_PINS-1:0] io_oe_n_o,
  input wire logic [nvx_pkg::NVX_PINS-1:0] pullup_en_o,
  input wire logic nv_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvx_pkg::*;
  logic [3:0] rel_cnt;
  logic [31:0] busy_cnt;
  default clocking dcb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // Cycles since reset release, saturating so it never wraps
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rel_cnt <= 4'h0;
    else if (rel_cnt != 4'hF)
      rel_cnt <= rel_cnt + 4'h1;
  end
  // Length of the running write cycle
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= nv_busy_o ? busy_cnt + 32'h1 : 32'h0;
  end
  property p_load_hold;
    rel_cnt < 4'h5 |-> io_oe_n_o == '1 && pullup_en_o == '0;
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("pins moved before shadow load");
  property p_tdo_fall;
    $changed(tdo_o) |-> !tck_i;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("test data out moved with clock high");
  property p_tdo_oe_fall;
    $changed(tdo_oe_n_o) |-> !tck_i;
  endproperty
  a_tdo_oe_fall: assert property (p_tdo_oe_fall) else $error("shift state left off falling edge");
  property p_io_open_drain;
    io_o == '0;
  endproperty
  a_io_open_drain: assert property (p_io_open_drain) else $error("pin driven high");
  property p_sda_open_drain;
    sda_o == 1'b0;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain) else $error("data line driven high");
  property p_sda_scl_low;
    $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("data line moved with clock high");
  property p_busy_len;
    $fell(nv_busy_o) |-> busy_cnt != 32'h0 && busy_cnt <= 32'(NV_WRITE_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
  property p_busy_after_stop;
    $rose(nv_busy_o) |-> scl_i && sda_i;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("write cycle began mid frame");
  c_nv_write: cover property ($rose(nv_busy_o));
  c_ack: cover property ($fell(sda_oe_n_o));
  c_shift: cover property ($fell(tdo_oe_n_o));
endmodule
bind nvx_core nvx_core_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_nvx_core_checker (.mclk_i(mclk_i),
  .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .tck_i(tck_i),
  .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .io_o(io_o), .io_oe_n_o(io_oe_n_o), .pullup_en_o(pullup_en_o),
  .nv_busy_o(nv_busy_o));

// File: nvx_i2c_master.sv
// Two-wire bus master model facing the expander's serial port
module nvx_i2c_master (
  // Clock
  input wire logic mclk_i,
  // Bus lines; data line level is resolved outside
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_drv_o,
  // Read results
  output logic [7:0] rd_data_o,
  output logic rd_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: clock stands high between frames
  initial
  begin
    scl_o = 1'b1;
    sda_drv_o = 1'b1;
    rd_data_o = 8'h00;
    rd_valid_o = 1'b0;
  end
  // Quarter bit: 10 cycles per phase keeps the 8-cycle minimum
  task automatic q();
    repeat (5) @(posedge mclk_i);
  endtask
  // Only this port is used; the test port stays idle meanwhile
  task automatic start();
    q();
    sda_drv_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    q();
    sda_drv_o <= 1'b0;
    q();
    q();
    scl_o <= 1'b0;
  endtask
  // Data set mid low phase, sampled mid high phase
  task automatic bit_slot(input logic b, output logic s);
    q();
    sda_drv_o <= b;
    q();
    scl_o <= 1'b1;
    q();
    s = sda_i;
    q();
    scl_o <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask
  // Last byte gets a not-acknowledge to end the read
  task automatic rbyte(input logic last);
    logic [7:0] b;
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(1'b1, b[i]);
    rd_data_o <= b;
    rd_valid_o <= 1'b1;
    @(posedge mclk_i);
    rd_valid_o <= 1'b0;
    bit_slot(last, s);
  endtask
  task automatic stop();
    q();
    sda_drv_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    q();
    sda_drv_o <= 1'b1;
    q();
    q();
  endtask
endmodule

// File: nvx_core_tb_top.sv
// Self-checking bench for the expander core
module nvx_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nvx_pkg::*;
  localparam int NWC = 300;
  logic mclk, rstn, scl, sda_drv, sda, sda_o, sda_oe_n, tck, tms, tdi, tdo, tdo_oe_n, busy, rd_valid;
  logic [2:0] sel;
  logic [8:0] io_ext, io_in, io_o, io_oe_n, pu;
  logic [7:0] rd_data;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int cmp_count = 0;
  // Pull-ups on the open-drain lines
  assign sda = sda_drv & sda_oe_n;
  assign io_in = io_ext & io_oe_n;
  nvx_core #(.NV_WRITE_CYCLES(NWC)) i_nvx_core (.mclk_i(mclk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_select_bit0_i(sel[0]), .addr_select_bit1_i(sel[1]),
    .addr_select_bit2_i(sel[2]), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
    .io_i(io_in), .io_o(io_o), .io_oe_n_o(io_oe_n), .pullup_en_o(pu), .nv_busy_o(busy));
  nvx_i2c_master i_nvx_i2c_master (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_drv_o(sda_drv),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Read results against the oldest note
  always @(posedge mclk)
    if (rd_valid === 1'b1)
      check(rd_data, exp_q.pop_front());
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    i_nvx_i2c_master.start();
    i_nvx_i2c_master.wbyte({NVX_DEV_ADDR_HI, sel, 1'b0}, k);
    check(k, 1'b1);
    i_nvx_i2c_master.wbyte(a, k);
    i_nvx_i2c_master.wbyte(d, k);
    check(k, 1'b1);
    i_nvx_i2c_master.stop();
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    logic k;
    i_nvx_i2c_master.start();
    i_nvx_i2c_master.wbyte({NVX_DEV_ADDR_HI, sel, 1'b0}, k);
    i_nvx_i2c_master.wbyte(a, k);
    i_nvx_i2c_master.start();
    i_nvx_i2c_master.wbyte({NVX_DEV_ADDR_HI, sel, 1'b1}, k);
    exp_q.push_back(e);
    i_nvx_i2c_master.rbyte(1'b1);
    i_nvx_i2c_master.stop();
  endtask
  // Busy must be up after the stop and end within the bound
  task automatic nv_wait();
    check(busy, 1'b1);
    for (int i = 0; i < 2 * NWC && busy !== 1'b0; i++)
      @(posedge mclk);
    check(busy, 1'b0);
  endtask
  // Test clock steps, LSB first; output bit sampled just before each rise
  task automatic jseq(input logic [63:0] m, input logic [63:0] d, input int n, output logic [63:0] o);
    for (int i = 0; i < n; i++)
    begin
      tms <= m[i];
      tdi <= d[i];
      repeat (10) @(posedge mclk);
      o[i] = tdo;
      tck <= 1'b1;
      repeat (10) @(posedge mclk);
      tck <= 1'b0;
    end
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (80000) @(posedge mclk);
    err_total++;
    end_sim();
  end
  initial
  begin
    logic [7:0] r;
    logic k;
    logic [63:0] o;
    r = 8'($urandom(90784));
    rstn = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    sel = 3'($urandom);
    io_ext = 9'($urandom);
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (12) @(posedge mclk);
    check(io_oe_n, 9'h1FF);
    check(pu, 9'h000);
    // Walk into shift-IR, shift three times, then back to reset
    jseq(64'h6, 64'($urandom), 7, o);
    check(o[5], 1'b1);
    repeat (10) @(posedge mclk);
    check(tdo_oe_n, 1'b0);
    jseq(64'h1F, 64'($urandom), 5, o);
    repeat (10) @(posedge mclk);
    check(tdo_oe_n, 1'b1);
    // Power-up defaults programmed with the disable bit clear
    reg_wr(NVX_PIN_DRIVE_CONTROL_LOW, 8'h00);
    check(io_oe_n, 9'h100);
    nv_wait();
    r = 8'($urandom);
    reg_wr(NVX_PULLUP_ENABLE_LOW, r);
    nv_wait();
    reg_wr(NVX_PULLUP_ENABLE_HIGH, 8'h01);
    nv_wait();
    check(pu, {1'b1, r});
    reg_rd(NVX_PULLUP_ENABLE_LOW, r);
    reg_rd(NVX_PIN_DRIVE_CONTROL_HIGH, 8'h01);
    // Disable bit set: shadow-only updates, no write cycle
    reg_wr(NVX_CONFIGURATION, 8'h01);
    nv_wait();
    reg_wr(NVX_PIN_DRIVE_CONTROL_HIGH, 8'h00);
    check(busy, 1'b0);
    reg_wr(NVX_PIN_DRIVE_CONTROL_LOW, 8'hFF);
    check(busy, 1'b0);
    check(io_oe_n, 9'h0FF);
    io_ext <= 9'($urandom);
    repeat (4) @(posedge mclk);
    reg_rd(NVX_PIN_LEVEL_STATUS_LOW, io_ext[7:0]);
    reg_rd(NVX_PIN_LEVEL_STATUS_HIGH, 8'h00);
    reg_rd(NVX_PIN_DRIVE_CONTROL_LOW, 8'hFF);
    // Second reset reloads shadows from the cells
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (12) @(posedge mclk);
    check(io_oe_n, 9'h100);
    check(pu, {1'b1, r});
    // Test port: load address, then read the pullup byte back
    jseq(64'h0000_0F80_3878_0386,
      {36'h0, NVX_IR_READ, 5'h0, NVX_PULLUP_ENABLE_LOW, 4'h0, NVX_IR_ADDRESS, 5'h0}, 44, o);
    check(o[39:32], r);
    i_nvx_i2c_master.start();
    i_nvx_i2c_master.wbyte({NVX_DEV_ADDR_HI, sel ^ 3'h5, 1'b0}, k);
    check(k, 1'b0);
    i_nvx_i2c_master.stop();
    // User cell write, then an address refused while busy
    r = 8'($urandom);
    reg_wr(NVX_USER_LAST, r);
    i_nvx_i2c_master.start();
    i_nvx_i2c_master.wbyte({NVX_DEV_ADDR_HI, sel, 1'b0}, k);
    check(k, 1'b0);
    i_nvx_i2c_master.stop();
    nv_wait();
    reg_rd(NVX_USER_LAST, r);
    repeat (20) @(posedge mclk);
    end_sim();
  end
endmodule
